/* File: hw/rsd_register_space.sv */
// Register window decoder: 256-byte window, port config, macrocell access, decode logic.
// Assumes host strobes are one-cycle pulses synchronous to clk, address stable with them.
`timescale 1ns/10ps
`default_nettype none

module rsd_register_space #(
  parameter logic [15:0] WINDOW_BASE = 16'h0000, // Register window base
  parameter logic [15:0] BOOT_BASE = 16'h8000,   // Boot flash base in program and data space
  parameter logic [15:0] SRAM_BASE = 16'h2000    // SRAM base
) (
  input wire logic clk,                  // 50 MHz clock
  input wire logic resetn,               // Synchronous reset, active low
  input wire logic ce,                   // Clock enable, freezes state when low unless resetn is low
  input wire logic [15:0] host_addr,     // Host address
  input wire logic [7:0] host_wdata,     // Host write data
  input wire logic host_wr,              // Write strobe, one cycle
  input wire logic host_rd,              // Read strobe, one cycle
  input wire logic host_ale,             // Address latch strobe, one cycle
  input wire logic host_psen,            // High for a program-space fetch
  output logic [7:0] host_rdata,         // Read data, registered
  input wire logic [31:0] pin_in,        // Pin levels, ports D..A
  output logic [31:0] pin_out,           // Pin output levels
  output logic [31:0] pin_oe,            // Pin output enables
  output logic [31:0] pin_open_drain,    // Open-drain select per pin
  output logic [31:0] pin_fast_slew,     // High slew select per pin
  input wire logic [31:0] cell_oe,       // Output enables from logic array, ports D..A
  input wire logic [31:0] cell_out,      // Logic array pin data, ports D..A
  input wire logic [23:0] input_cells,   // Input macrocells, ports C..A
  input wire logic [15:0] cell_next,     // Macrocell next state from logic array, BC:AB
  input wire logic cell_clk_en,          // Macrocell clocking from logic array
  input wire logic [7:0] main_prot,      // Main flash sector protect flags
  input wire logic [3:0] boot_prot,      // Boot flash sector protect flags
  input wire logic secure,               // Device security bit
  output logic [15:0] cell_q,            // Output_cells_bc:AB
  output logic [7:0] page_q,             // Page register
  output logic [4:0] mem_map_q,          // Memory-space map bits
  output logic [7:0] pwr2_q,             // Power control 2 contents
  output logic test_port_en,             // Test port enable
  output logic turbo_off,                // Logic array in low-power latch mode
  output rsd_pkg::rsd_selects_t selects  // Memory selects
);

  rsd_pkg::rsd_state_t s_q;
  rsd_pkg::rsd_state_t s_d;

  logic in_window;
  logic [7:0] ofs;
  logic [15:0] eff_addr;
  logic [31:0] oe_live;
  logic pins_moved;
  logic [15:0] cell_live;

  function automatic logic hit(input logic [7:0] o, input logic [7:0] want);
    hit = (o == want);
  endfunction

  // Port index for per-port registers, -1 style encoded by valid flag
  function automatic logic [2:0] port_of(input logic [7:0] o, input logic [7:0] a, input logic [7:0] b,
                                         input logic [7:0] c, input logic [7:0] d);
    port_of = hit(o, a) ? 3'b100 : hit(o, b) ? 3'b101 : hit(o, c) ? 3'b110 : hit(o, d) ? 3'b111 : 3'b000;
  endfunction

  assign in_window = (host_addr[15:8] == WINDOW_BASE[15:8]);
  assign ofs = host_addr[7:0];
  assign eff_addr = host_addr;

  // Pin drivers
  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++) begin : g_port
      for (genvar gb = 0; gb < 8; gb++) begin : g_bit
        localparam int I = gp * 8 + gb;
        logic addr_mode;
        // Only ports A and B carry latched address
        assign addr_mode = (gp < 2) ? s_q.port[gp].ctrl[gb] : 1'b0;
        // One assignment per bit, so no two processes share a driven variable
        // Latched address wins over MCU output, which wins over the logic array
        assign pin_out[I] = addr_mode ? s_q.lat_addr[gb] :
                            s_q.port[gp].dir[gb] ? s_q.port[gp].out[gb] :
                            cell_out[I];
        assign oe_live[I] = addr_mode | s_q.port[gp].dir[gb] | cell_oe[I];
        // Open drain only exists on ports A and C; others read the bit as slew
        assign pin_open_drain[I] = (gp == 0 || gp == 2) ? s_q.port[gp].drv[gb] : 1'b0;
        assign pin_fast_slew[I] = (gp == 0 || gp == 2) ? 1'b0 : s_q.port[gp].drv[gb];
      end
    end
  endgenerate

  assign pin_oe = oe_live;

  // In low-power mode the macrocells sleep until the pins feeding the array move
  assign pins_moved = (s_q.pld_in_hold != pin_in);
  assign cell_live = {s_q.omc_bc, s_q.omc_ab};

  always_comb begin
    logic [2:0] pi;
    logic [7:0] rd;
    s_d = s_q;
    pi = 3'b000;
    rd = rsd_pkg::UNMAPPED_RD;

    if (host_ale) begin
      s_d.lat_addr = {host_addr[7:0], host_addr[7:0]};
    end

    // Low-power hold: capture inputs only when they move
    if (s_q.pld_in_hold != pin_in) begin
      s_d.pld_in_hold = pin_in;
    end

    // Macrocells clocked by the array unless the host writes that macrocell register this cycle or the array sleeps
    if (cell_clk_en && (!turbo_off || pins_moved)) begin
      s_d.omc_ab = cell_next[7:0];
      s_d.omc_bc = cell_next[15:8];
    end

    if (host_wr && in_window) begin
      pi = port_of(ofs, rsd_pkg::OFS_A_CTRL, rsd_pkg::OFS_B_CTRL, 8'hff, 8'hff);
      // Only ports A and B have control; the unused C and D slots of the lookup could match 0xff
      if (pi[2] && !pi[1]) s_d.port[pi[1:0]].ctrl = host_wdata;
      pi = port_of(ofs, rsd_pkg::OFS_A_OUT, rsd_pkg::OFS_B_OUT, rsd_pkg::OFS_C_OUT, rsd_pkg::OFS_D_OUT);
      if (pi[2]) s_d.port[pi[1:0]].out = host_wdata;
      pi = port_of(ofs, rsd_pkg::OFS_A_DIR, rsd_pkg::OFS_B_DIR, rsd_pkg::OFS_C_DIR, rsd_pkg::OFS_D_DIR);
      if (pi[2]) s_d.port[pi[1:0]].dir = host_wdata;
      pi = port_of(ofs, rsd_pkg::OFS_A_DRV, rsd_pkg::OFS_B_DRV, rsd_pkg::OFS_C_DRV, rsd_pkg::OFS_D_DRV);
      if (pi[2]) s_d.port[pi[1:0]].drv = host_wdata;
      if (hit(ofs, rsd_pkg::OFS_OMC_AB)) begin
        s_d.omc_ab = (host_wdata & ~s_q.mask_ab) | (s_q.omc_ab & s_q.mask_ab);
      end
      if (hit(ofs, rsd_pkg::OFS_OMC_BC)) begin
        s_d.omc_bc = (host_wdata & ~s_q.mask_bc) | (s_q.omc_bc & s_q.mask_bc);
      end
      if (hit(ofs, rsd_pkg::OFS_MASK_AB)) s_d.mask_ab = host_wdata;
      if (hit(ofs, rsd_pkg::OFS_MASK_BC)) s_d.mask_bc = host_wdata;
      if (hit(ofs, rsd_pkg::OFS_PWR0)) s_d.pwr0 = host_wdata;
      if (hit(ofs, rsd_pkg::OFS_PWR2)) s_d.pwr2 = host_wdata;
      if (hit(ofs, rsd_pkg::OFS_TEST_EN)) s_d.test_en = host_wdata;
      if (hit(ofs, rsd_pkg::OFS_PAGE)) s_d.page = host_wdata;
      if (hit(ofs, rsd_pkg::OFS_MEM_MAP)) s_d.mem_map = host_wdata;
    end

    if (host_rd && in_window) begin
      unique case (ofs)
        rsd_pkg::OFS_A_PIN: rd = pin_in[7:0];
        rsd_pkg::OFS_B_PIN: rd = pin_in[15:8];
        rsd_pkg::OFS_C_PIN: rd = pin_in[23:16];
        rsd_pkg::OFS_D_PIN: rd = pin_in[31:24];
        rsd_pkg::OFS_A_CTRL: rd = s_q.port[0].ctrl;
        rsd_pkg::OFS_B_CTRL: rd = s_q.port[1].ctrl;
        rsd_pkg::OFS_A_OUT: rd = s_q.port[0].out;
        rsd_pkg::OFS_B_OUT: rd = s_q.port[1].out;
        rsd_pkg::OFS_C_OUT: rd = s_q.port[2].out;
        rsd_pkg::OFS_D_OUT: rd = s_q.port[3].out;
        rsd_pkg::OFS_A_DIR: rd = s_q.port[0].dir;
        rsd_pkg::OFS_B_DIR: rd = s_q.port[1].dir;
        rsd_pkg::OFS_C_DIR: rd = s_q.port[2].dir;
        rsd_pkg::OFS_D_DIR: rd = s_q.port[3].dir;
        rsd_pkg::OFS_A_DRV: rd = s_q.port[0].drv;
        rsd_pkg::OFS_B_DRV: rd = s_q.port[1].drv;
        rsd_pkg::OFS_C_DRV: rd = s_q.port[2].drv;
        rsd_pkg::OFS_D_DRV: rd = s_q.port[3].drv;
        rsd_pkg::OFS_A_IMC: rd = input_cells[7:0];
        rsd_pkg::OFS_B_IMC: rd = input_cells[15:8];
        rsd_pkg::OFS_C_IMC: rd = input_cells[23:16];
        rsd_pkg::OFS_A_OES: rd = oe_live[7:0];
        rsd_pkg::OFS_B_OES: rd = oe_live[15:8];
        rsd_pkg::OFS_C_OES: rd = oe_live[23:16];
        rsd_pkg::OFS_D_OES: rd = oe_live[31:24];
        rsd_pkg::OFS_OMC_AB: rd = cell_live[7:0];
        rsd_pkg::OFS_OMC_BC: rd = cell_live[15:8];
        rsd_pkg::OFS_MASK_AB: rd = s_q.mask_ab;
        rsd_pkg::OFS_MASK_BC: rd = s_q.mask_bc;
        rsd_pkg::OFS_PWR0: rd = s_q.pwr0;
        rsd_pkg::OFS_PWR2: rd = s_q.pwr2;
        rsd_pkg::OFS_MAIN_PROT: rd = main_prot;
        rsd_pkg::OFS_BOOT_PROT: rd = {secure, 3'b000, boot_prot};
        rsd_pkg::OFS_TEST_EN: rd = s_q.test_en;
        rsd_pkg::OFS_PAGE: rd = s_q.page;
        rsd_pkg::OFS_MEM_MAP: rd = s_q.mem_map;
        default: rd = rsd_pkg::UNMAPPED_RD;
      endcase
      s_d.rdata = rd;
    end

    if (!resetn) begin
      s_d = '0;
      s_d.mem_map = rsd_pkg::RST_MEM_MAP;
      s_d.rdata = rsd_pkg::RST_ZERO;
    end
  end

  always_ff @(posedge clk) begin
    if (ce || !resetn) begin
      s_q <= s_d;
    end
  end

  // Address decode logic: page extends the address; map picks program or data space
  always_comb begin
    logic prog_fetch;
    logic boot_hit;
    logic sram_hit;
    prog_fetch = host_psen;
    boot_hit = (eff_addr[15:14] == BOOT_BASE[15:14]) &&
               (prog_fetch ? s_q.mem_map[1] : s_q.mem_map[3]);
    sram_hit = (eff_addr[15:13] == SRAM_BASE[15:13]) && !prog_fetch && !in_window;
    selects.window_sel = in_window;
    selects.sram_sel = sram_hit;
    selects.boot_sel = '0;
    selects.main_sel = '0;
    if (boot_hit) begin
      selects.boot_sel[eff_addr[13:12]] = 1'b1;
    end else if (!sram_hit && !in_window &&
                 (prog_fetch ? s_q.mem_map[2] : (s_q.mem_map[4] | s_q.mem_map[0]))) begin
      selects.main_sel[{s_q.page[0], eff_addr[15:14]}] = 1'b1;
    end
  end

  assign host_rdata = s_q.rdata;
  assign cell_q = cell_live;
  assign page_q = s_q.page;
  assign mem_map_q = s_q.mem_map[4:0];
  assign pwr2_q = s_q.pwr2;
  assign test_port_en = s_q.test_en[0];
  assign turbo_off = s_q.pwr0[rsd_pkg::PWR0_TURBO_OFF_BIT];

endmodule

`default_nettype wire

/* File: shared/rsd_pkg.sv */
// Register window decoder package: offsets, field layouts, reset values.
// Assumes a byte-wide host bus presenting a 16-bit address and one-cycle strobes.
package rsd_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int PAGE_W = 8;

  // Window offsets
  localparam logic [7:0] OFS_A_PIN = 8'h00;
  localparam logic [7:0] OFS_B_PIN = 8'h01;
  localparam logic [7:0] OFS_A_CTRL = 8'h02;
  localparam logic [7:0] OFS_B_CTRL = 8'h03;
  localparam logic [7:0] OFS_A_OUT = 8'h04;
  localparam logic [7:0] OFS_B_OUT = 8'h05;
  localparam logic [7:0] OFS_A_DIR = 8'h06;
  localparam logic [7:0] OFS_B_DIR = 8'h07;
  localparam logic [7:0] OFS_A_DRV = 8'h08;
  localparam logic [7:0] OFS_B_DRV = 8'h09;
  localparam logic [7:0] OFS_A_IMC = 8'h0a;
  localparam logic [7:0] OFS_B_IMC = 8'h0b;
  localparam logic [7:0] OFS_A_OES = 8'h0c;
  localparam logic [7:0] OFS_B_OES = 8'h0d;
  localparam logic [7:0] OFS_C_PIN = 8'h10;
  localparam logic [7:0] OFS_D_PIN = 8'h11;
  localparam logic [7:0] OFS_C_OUT = 8'h12;
  localparam logic [7:0] OFS_D_OUT = 8'h13;
  localparam logic [7:0] OFS_C_DIR = 8'h14;
  localparam logic [7:0] OFS_D_DIR = 8'h15;
  localparam logic [7:0] OFS_C_DRV = 8'h16;
  localparam logic [7:0] OFS_D_DRV = 8'h17;
  localparam logic [7:0] OFS_C_IMC = 8'h18;
  localparam logic [7:0] OFS_C_OES = 8'h1a;
  localparam logic [7:0] OFS_D_OES = 8'h1b;
  localparam logic [7:0] OFS_OMC_AB = 8'h20;
  localparam logic [7:0] OFS_OMC_BC = 8'h21;
  localparam logic [7:0] OFS_MASK_AB = 8'h22;
  localparam logic [7:0] OFS_MASK_BC = 8'h23;
  localparam logic [7:0] OFS_PWR0 = 8'hb0;
  localparam logic [7:0] OFS_PWR2 = 8'hb4;
  localparam logic [7:0] OFS_MAIN_PROT = 8'hc0;
  localparam logic [7:0] OFS_BOOT_PROT = 8'hc2;
  localparam logic [7:0] OFS_TEST_EN = 8'hc7;
  localparam logic [7:0] OFS_PAGE = 8'he0;
  localparam logic [7:0] OFS_MEM_MAP = 8'he2;

  // Field positions
  localparam int PWR0_TURBO_OFF_BIT = 3;
  localparam int BOOT_PROT_SECURE_BIT = 7;
  localparam int MAP_W = 5;

  // Reset values and unmapped read value
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_MEM_MAP = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'hff;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] out;
    logic [7:0] dir;
    logic [7:0] drv;
  } rsd_port_cfg_t;

  typedef struct packed {
    rsd_port_cfg_t [3:0] port;
    logic [7:0] omc_ab;
    logic [7:0] omc_bc;
    logic [7:0] mask_ab;
    logic [7:0] mask_bc;
    logic [7:0] pwr0;
    logic [7:0] pwr2;
    logic [7:0] test_en;
    logic [7:0] page;
    logic [7:0] mem_map;
    logic [7:0] rdata;
    logic [15:0] lat_addr;
    logic [31:0] pld_in_hold;
  } rsd_state_t;

  // Memory selects leaving the decode logic
  typedef struct packed {
    logic [7:0] main_sel;
    logic [3:0] boot_sel;
    logic sram_sel;
    logic window_sel;
  } rsd_selects_t;

endpackage

/* File: bench/rsd_monitor.sv */
// Checker for the register window decoder, seeing only its top ports.
// Assumes the host keeps its strobes one cycle long; accesses with ce low are not taken.
`timescale 1ns/10ps
`default_nettype none
module rsd_monitor #(
  parameter logic [15:0] WINDOW_BASE = 16'h0000 // Window base
) (
  input wire logic clk, // Clock
  input wire logic resetn, // Reset, active low
  input wire logic ce, // Clock enable
  input wire logic [15:0] host_addr, // Address
  input wire logic [7:0] host_wdata, // Write data
  input wire logic host_wr, // Write strobe
  input wire logic host_rd, // Read strobe
  input wire logic [7:0] host_rdata, // Read data
  input wire logic [31:0] pin_in, // Pin levels
  input wire logic [31:0] pin_oe, // Pin enables
  input wire logic [31:0] pin_open_drain, // Open-drain selects
  input wire logic [7:0] main_prot, // Main protect flags
  input wire logic [3:0] boot_prot, // Boot protect flags
  input wire logic secure, // Security bit
  input wire logic [7:0] page_q, // Page register
  input wire logic turbo_off // Low-power latch mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic rd_hit;
  logic wr_hit;
  assign rd_hit = ce && host_rd && host_addr[15:8] == WINDOW_BASE[15:8];
  assign wr_hit = ce && host_wr && host_addr[15:8] == WINDOW_BASE[15:8];
  property p_unmapped; rd_hit && host_addr[7:0] inside {[8'h24:8'haf]} |=> host_rdata == 8'hff; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not fixed");
  property p_outside; host_rd && !rd_hit |=> $stable(host_rdata); endproperty
  a_outside: assert property (p_outside) else $error("read outside window answered");
  property p_pin_a; rd_hit && host_addr[7:0] == 8'h00 |=> host_rdata == $past(pin_in[7:0]); endproperty
  a_pin_a: assert property (p_pin_a) else $error("pin read wrong");
  property p_oes_d; rd_hit && host_addr[7:0] == 8'h1b |=> host_rdata == $past(pin_oe[31:24]); endproperty
  a_oes_d: assert property (p_oes_d) else $error("enable status wrong");
  property p_main; rd_hit && host_addr[7:0] == 8'hc0 |=> host_rdata == $past(main_prot); endproperty
  a_main: assert property (p_main) else $error("main protect read wrong");
  property p_boot; rd_hit && host_addr[7:0] == 8'hc2 |=> host_rdata == {$past(secure), 3'b000, $past(boot_prot)}; endproperty
  a_boot: assert property (p_boot) else $error("boot protect read wrong");
  property p_page; wr_hit && host_addr[7:0] == 8'he0 |=> page_q == $past(host_wdata); endproperty
  a_page: assert property (p_page) else $error("page write lost");
  property p_turbo; wr_hit && host_addr[7:0] == 8'hb0 |=> turbo_off == $past(host_wdata[3]); endproperty
  a_turbo: assert property (p_turbo) else $error("turbo bit wrong");
  property p_drive; wr_hit && host_addr[7:0] == 8'h08 |=> pin_open_drain[7:0] == $past(host_wdata); endproperty
  a_drive: assert property (p_drive) else $error("open drain select wrong");
endmodule
bind rsd_register_space rsd_monitor #(.WINDOW_BASE(WINDOW_BASE)) u_rsd_monitor (.clk(clk), .resetn(resetn), .ce(ce),
  .host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata),
  .pin_in(pin_in), .pin_oe(pin_oe), .pin_open_drain(pin_open_drain), .main_prot(main_prot),
  .boot_prot(boot_prot), .secure(secure), .page_q(page_q), .turbo_off(turbo_off));
`default_nettype wire

/* File: bench/rsd_host_model.sv */
// Host processor model: byte reads, writes and address latch strobes.
// Assumes callers enter its tasks just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module rsd_host_model (
  input wire logic clk, // Clock
  input wire logic [7:0] host_rdata, // Read data
  output logic [15:0] host_addr, // Address
  output logic [7:0] host_wdata, // Write data
  output logic host_wr, // Write strobe
  output logic host_rd, // Read strobe
  output logic host_ale // Address latch strobe
);
  initial begin
    host_addr = 16'h0000;
    host_wdata = 8'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_ale = 1'b0;
  end
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [7:0] wd, output logic [7:0] rd_data);
    host_addr <= a;
    host_wdata <= wd;
    host_wr <= wr;
    host_rd <= !wr;
    @(posedge clk);
    host_wr <= 1'b0;
    host_rd <= 1'b0;
    // Released lines show the inverse, so a stale copy never passes
    host_addr <= ~a;
    host_wdata <= ~wd;
    @(posedge clk);
    rd_data = host_rdata;
  endtask
  task automatic latch_addr(input logic [15:0] a);
    host_addr <= a;
    host_ale <= 1'b1;
    @(posedge clk);
    host_ale <= 1'b0;
    host_addr <= ~a;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: bench/test_mcu_register_space_decoder.sv */
// Testbench for the register window decoder: table of accesses, then hand cases.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module test_mcu_register_space_decoder;
  localparam logic [15:0] BASE = 16'h3000;
  typedef struct packed {logic [7:0] ofs; logic [7:0] wd; logic [7:0] exp;} rsd_row_t;
  localparam rsd_row_t ROWS [19] = '{'{8'h02, 8'h00, 8'h00}, '{8'h04, 8'ha5, 8'ha5}, '{8'h06, 8'hf0, 8'hf0},
    '{8'h08, 8'h3c, 8'h3c}, '{8'h09, 8'hc3, 8'hc3}, '{8'h13, 8'h69, 8'h69}, '{8'h15, 8'h96, 8'h96},
    '{8'h1b, 8'h77, 8'h96}, '{8'hc7, 8'h01, 8'h01},
    '{8'he0, 8'h81, 8'h81}, '{8'hb4, 8'h55, 8'h55}, '{8'h00, 8'h77, 8'h11}, '{8'h11, 8'h77, 8'h44},
    '{8'h0a, 8'h77, 8'h5a}, '{8'h18, 8'h77, 8'hc3}, '{8'hc0, 8'h77, 8'h96}, '{8'hc2, 8'h77, 8'h8a},
    '{8'h40, 8'h77, 8'hff}, '{8'h0e, 8'h77, 8'hff}};
  logic clk, resetn, ce, host_psen, host_wr, host_rd, host_ale, cell_clk_en, secure, turbo_off, test_port_en;
  rsd_pkg::rsd_selects_t selects;
  logic [15:0] host_addr, cell_next, cell_q;
  logic [7:0] host_wdata, host_rdata, main_prot, page_q, pwr2_q, d;
  logic [31:0] pin_in, pin_out, pin_open_drain, pin_fast_slew;
  logic [23:0] input_cells;
  logic [3:0] boot_prot;
  logic [4:0] mem_map_q;
  int err_count, comparisons, cycles;
  rsd_register_space #(.WINDOW_BASE(BASE)) u_rsd_register_space (.clk(clk), .resetn(resetn), .ce(ce),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd), .host_ale(host_ale),
    .host_psen(host_psen), .host_rdata(host_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(),
    .pin_open_drain(pin_open_drain), .pin_fast_slew(pin_fast_slew), .cell_oe(32'h0000_0000),
    .cell_out(32'h0000_0000), .input_cells(input_cells), .cell_next(cell_next), .cell_clk_en(cell_clk_en),
    .main_prot(main_prot), .boot_prot(boot_prot), .secure(secure), .cell_q(cell_q), .page_q(page_q),
    .mem_map_q(mem_map_q), .pwr2_q(pwr2_q), .test_port_en(test_port_en), .turbo_off(turbo_off),
    .selects(selects));
  rsd_host_model u_rsd_host_model (.clk(clk), .host_rdata(host_rdata), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd), .host_ale(host_ale));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] v);
    u_rsd_host_model.xfer(1'b1, BASE | 16'(ofs), v, d);
  endtask
  task automatic rd(input logic [7:0] ofs);
    u_rsd_host_model.xfer(1'b0, BASE | 16'(ofs), 8'h00, d);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    host_psen = 1'b0;
    pin_in = 32'h4433_2211;
    input_cells = 24'hc3_a55a;
    cell_next = 16'h1234;
    cell_clk_en = 1'b0;
    main_prot = 8'h96;
    boot_prot = 4'ha;
    secure = 1'b1;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    foreach (ROWS[i]) begin
      wr(ROWS[i].ofs, ROWS[i].wd);
      rd(ROWS[i].ofs);
      check($sformatf("offset %h", ROWS[i].ofs), 32'(ROWS[i].exp), 32'(d));
    end
    check("power 2 and test port", 32'h0000_00ab, {pwr2_q, test_port_en});
    check("port a drive", 32'h00a0, {pin_out[7:0] & 8'hf0});
    check("drive select", 32'h3cc3, {pin_open_drain[7:0], pin_fast_slew[15:8]});
    rd(8'he0);
    u_rsd_host_model.xfer(1'b1, 16'h40e0, 8'h12, d);
    u_rsd_host_model.xfer(1'b0, 16'h40e0, 8'h00, d);
    // A read outside the window is not taken, so the page value read before still stands
    check("outside read", 32'h0081, 32'(d));
    check("page after outside write", 32'h0081, 32'(page_q));
    ce <= 1'b0;
    wr(8'he0, 8'h5a);
    ce <= 1'b1;
    check("page frozen by clock enable", 32'h0000_0081, 32'(page_q));
    wr(8'h22, 8'h0f);
    wr(8'h20, 8'hff);
    wr(8'h23, 8'h00);
    wr(8'h21, 8'h3c);
    rd(8'h20);
    check("masked cells", 32'h3cf0_f0, {cell_q, d});
    cell_clk_en <= 1'b1;
    @(posedge clk);
    cell_clk_en <= 1'b0;
    @(posedge clk);
    check("cells clocked", 32'h1234, 32'(cell_q));
    wr(8'h02, 8'hff);
    wr(8'h03, 8'hff);
    u_rsd_host_model.latch_addr(16'h009c);
    check("latched address", 32'h9c9c, 32'(pin_out[15:0]));
    wr(8'hb0, 8'h08);
    wr(8'he2, 8'h1f);
    check("turbo and map", 32'h003f, {turbo_off, mem_map_q});
    // Released address is the inverse of 0x30e2: main flash, upper page half, data fetch
    check("data decode", 32'h0000_2000, 32'(selects));
    host_psen <= 1'b1;
    wr(8'he2, 8'h1b);
    check("program decode", 32'h0000_0000, 32'(selects));
    cell_next <= 16'h5678;
    cell_clk_en <= 1'b1;
    @(posedge clk);
    pin_in <= 32'h4433_2212;
    @(posedge clk);
    check("cells held in low power", 32'h0000_1234, 32'(cell_q));
    cell_clk_en <= 1'b0;
    @(posedge clk);
    check("cells clocked on input change", 32'h0000_5678, 32'(cell_q));
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    #1;
    check("after reset", 32'h0000_0000, {page_q, cell_q, host_rdata});
    check("turbo after reset", 32'h0000_0000, 32'(turbo_off));
    conclude();
  end
endmodule
`default_nettype wire
